// ---- core/timer_pair_pkg.sv ----
package timer_pair_pkg;
  // wishbone word byte addresses
  localparam logic [5:0] ADDR_MODE_A   = 6'h00;
  localparam logic [5:0] ADDR_MODE_B   = 6'h04;
  localparam logic [5:0] ADDR_FLOP     = 6'h08;
  localparam logic [5:0] ADDR_RUN      = 6'h0C;
  localparam logic [5:0] ADDR_DBUF     = 6'h10;
  localparam logic [5:0] ADDR_CMP0     = 6'h14;
  localparam logic [5:0] ADDR_CMP1     = 6'h18;
  localparam logic [5:0] ADDR_CMP2     = 6'h1C;
  localparam logic [5:0] ADDR_CMP3     = 6'h20;
  // mode register fields
  localparam int MODE_LCLK_LSB = 0;
  localparam int MODE_UCLK_LSB = 2;
  localparam int MODE_PWM_LSB  = 4;
  localparam int MODE_PAIR_LSB = 6;
  // flop control register fields
  localparam int FLOP_A_CTL_LSB = 0;
  localparam int FLOP_A_INV_BIT = 2;
  localparam int FLOP_A_SRC_BIT = 3;
  localparam int FLOP_B_CTL_LSB = 4;
  localparam int FLOP_B_INV_BIT = 6;
  localparam int FLOP_B_SRC_BIT = 7;
  // run register fields
  localparam int RUN_LOWER_A_BIT = 0;
  localparam int RUN_UPPER_A_BIT = 1;
  localparam int RUN_LOWER_B_BIT = 2;
  localparam int RUN_UPPER_B_BIT = 3;
  localparam int RUN_PRESCALE_BIT = 7;
  // double buffer register fields
  localparam int DBUF_A_BIT = 0;
  localparam int DBUF_B_BIT = 1;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] FLOP_RESET = 8'h33;
  localparam logic [7:0] RUN_RESET  = 8'h00;
  localparam logic [7:0] DBUF_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET  = 8'h00;
  // prescaler tap positions
  localparam int TAP_FINE_BIT   = 0;
  localparam int TAP_MID_BIT    = 3;
  localparam int TAP_COARSE_BIT = 7;
  localparam int PRESCALE_WIDTH = 9;
  // flop control codes
  localparam logic [1:0] FLOP_INVERT = 2'h0;
  localparam logic [1:0] FLOP_SET    = 2'h1;
  localparam logic [1:0] FLOP_CLEAR  = 2'h2;
  localparam logic [1:0] FLOP_HOLD   = 2'h3;
  typedef enum logic [1:0] {
    MODE_DUAL8,
    MODE_CASCADE16,
    MODE_PPG,
    MODE_PWM
  } pair_mode_t;
endpackage : timer_pair_pkg

// ---- core/timer_pair_block.sv ----
// How it works
// - in 8-bit mode with toggling on, every selected match flips the output
// - control code 00 inverts the output flop at once, running or not
// - code 10 clears the output flop, code 01 sets it
// - output flop and compare registers read back as zero
// - in 8-bit mode the upper timer can count lower-timer matches
// - mode 01 cascades: lower overflow clocks upper, upper clock select ignored
// - 16-bit: low byte first; that write halts compare until high byte written
// - 16-bit: a lower match alone does not clear the lower counter
// - 16-bit: both matching clears both, raises upper irq, toggles output
// - mode 10 is PPG on the lower timer, driving the pair output
// - PPG: output inverts on lower-compare and on upper-compare equality
// - PPG with double buffer: reload lower compare on upper-compare match
// - PPG: upper timer still counts when its run bit is set
// - PWM only on the lower timer; upper stays an ordinary 8-bit timer
// - PWM: invert on compare and on 2^n-1 overflow, which clears counter
// - PWM with double buffer: reload lower compare on 2^n-1 overflow
// - mode 00 dual 8-bit, 01 16-bit, 10 PPG, 11 PWM
// - lower clock select picks prescaler taps 01-11; external only pair b
// - dual 8-bit: upper clock select picks lower match or a tap
// - dual 8-bit: source bit 0 picks lower match, 1 upper match
// - 8-bit mode: a match clears that counter and raises its irq
// - compare value 00 matches on counter overflow
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module timer_pair_unit
  import timer_pair_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // configuration
  input  wire logic [7:0] mode_reg,
  input  wire logic [1:0] flop_control_field,
  input  wire logic       flop_ctl_write,
  input  wire logic       toggle_enable,
  input  wire logic       toggle_source_select,
  input  wire logic       run_lower,
  input  wire logic       run_upper,
  input  wire logic       dbuf_enable,
  // compare register writes
  input  wire logic       cmp_lower_write,
  input  wire logic       cmp_upper_write,
  input  wire logic [7:0] cmp_wdata,
  // clock ticks
  input  wire logic [2:0] taps,
  input  wire logic       ext_tick,
  input  wire logic       has_ext,
  // outputs
  output logic            lower_match_irq,
  output logic            upper_match_irq,
  output logic            toggle_out
);
  logic [7:0] count_lower;
  logic [7:0] count_upper;
  logic [7:0] cmp_lower;
  logic [7:0] cmp_upper;
  logic [7:0] cmp_buffer;
  logic       cmp_hold;
  pair_mode_t mode;
  logic [1:0] lclk;
  logic [1:0] uclk;
  logic [1:0] pwm_sel;
  logic       tick_lower;
  logic       tick_upper;
  logic       match_lower;
  logic       match_upper;
  logic       ovf_lower;
  logic       pwm_top;
  logic [7:0] pwm_limit;
  logic       clr_lower;
  logic       clr_upper;
  logic       both16;
  logic       ppg_lo;
  logic       ppg_hi;
  logic       flip;

  assign mode    = pair_mode_t'(mode_reg[MODE_PAIR_LSB +: 2]);
  assign lclk    = mode_reg[MODE_LCLK_LSB +: 2];
  assign uclk    = mode_reg[MODE_UCLK_LSB +: 2];
  assign pwm_sel = mode_reg[MODE_PWM_LSB +: 2];

  // lower clock: code 00 is the external input where present
  always_comb
  begin
    case (lclk)
      2'h1:    tick_lower = taps[0];
      2'h2:    tick_lower = taps[1];
      2'h3:    tick_lower = taps[2];
      default: tick_lower = has_ext & ext_tick;
    endcase
  end

  assign ovf_lower = tick_lower && (count_lower == 8'hFF);
  // compare 00 fires on the wrap from FF
  assign match_lower = run_lower && !cmp_hold && tick_lower &&
                       ((cmp_lower == 8'h00) ? (count_lower == 8'hFF)
                                              : (count_lower + 8'h01 == cmp_lower));

  always_comb
  begin
    case (pwm_sel)
      2'h1:    pwm_limit = 8'h3F;
      2'h2:    pwm_limit = 8'h7F;
      default: pwm_limit = 8'hFF;
    endcase
  end
  assign pwm_top = (mode == MODE_PWM) && run_lower && tick_lower &&
                   (count_lower + 8'h01 == pwm_limit);

  // PPG upper-compare equality on the lower counter
  assign ppg_lo = (mode == MODE_PPG) && match_lower;
  assign ppg_hi = (mode == MODE_PPG) && run_lower && tick_lower &&
                  (count_lower + 8'h01 == cmp_upper);

  always_comb
  begin
    if (mode == MODE_CASCADE16)
      tick_upper = run_lower && ovf_lower;
    else
      case (uclk)
        2'h0:    tick_upper = match_lower;
        2'h1:    tick_upper = taps[0];
        2'h2:    tick_upper = taps[1];
        default: tick_upper = taps[2];
      endcase
  end

  assign match_upper = run_upper && !cmp_hold && tick_upper &&
                       ((cmp_upper == 8'h00) ? (count_upper == 8'hFF)
                                              : (count_upper + 8'h01 == cmp_upper));

  // 16-bit terminal count: both halves equal together
  assign both16 = (mode == MODE_CASCADE16) && !cmp_hold && run_lower && tick_lower &&
                  (count_lower + 8'h01 == cmp_lower) &&
                  (count_upper == cmp_upper);

  always_comb
  begin
    clr_lower = 1'b0;
    clr_upper = 1'b0;
    case (mode)
      MODE_DUAL8:
      begin
        clr_lower = match_lower;
        clr_upper = match_upper;
      end
      MODE_CASCADE16:
      begin
        clr_lower = both16;
        clr_upper = both16;
      end
      MODE_PPG:
      begin
        clr_lower = ppg_hi;
        clr_upper = match_upper;
      end
      default:
      begin
        clr_lower = pwm_top;
        clr_upper = match_upper;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count_lower <= 8'h00;
    else if (!run_lower)
      count_lower <= 8'h00;
    else if (clr_lower)
      count_lower <= 8'h00;
    else if (tick_lower)
      count_lower <= count_lower + 8'h01;
  end

  // upper counter is unused in PPG unless its run bit is set
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count_upper <= 8'h00;
    else if (!run_upper && !(mode == MODE_CASCADE16 && run_lower))
      count_upper <= 8'h00;
    else if (clr_upper)
      count_upper <= 8'h00;
    else if (tick_upper)
      count_upper <= count_upper + 8'h01;
  end

  // lower compare register and its buffer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmp_lower  <= CMP_RESET;
      cmp_buffer <= CMP_RESET;
    end
    else
    begin
      if (cmp_lower_write)
        cmp_buffer <= cmp_wdata;
      if (cmp_lower_write && !dbuf_enable)
        cmp_lower <= cmp_wdata;
      else if (dbuf_enable && ppg_hi)
        cmp_lower <= cmp_buffer;
      else if (dbuf_enable && pwm_top)
        cmp_lower <= cmp_buffer;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cmp_upper <= CMP_RESET;
    else if (cmp_upper_write)
      cmp_upper <= cmp_wdata;
  end

  // low-byte write suspends 16-bit compare until the high byte lands
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cmp_hold <= 1'b0;
    else if (cmp_upper_write)
      cmp_hold <= 1'b0;
    else if (cmp_lower_write && mode == MODE_CASCADE16)
      cmp_hold <= 1'b1;
  end

  always_comb
  begin
    case (mode)
      MODE_DUAL8:     flip = toggle_source_select ? match_upper : match_lower;
      MODE_CASCADE16: flip = both16;
      MODE_PPG:       flip = ppg_lo || ppg_hi;
      default:        flip = match_lower || pwm_top;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      toggle_out <= 1'b0;
    else if (flop_ctl_write && flop_control_field == FLOP_INVERT)
      toggle_out <= ~toggle_out;
    else if (flop_ctl_write && flop_control_field == FLOP_CLEAR)
      toggle_out <= 1'b0;
    else if (flop_ctl_write && flop_control_field == FLOP_SET)
      toggle_out <= 1'b1;
    else if (toggle_enable && flip)
      toggle_out <= ~toggle_out;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lower_match_irq <= 1'b0;
      upper_match_irq <= 1'b0;
    end
    else
    begin
      lower_match_irq <= (mode == MODE_CASCADE16) ? 1'b0 : match_lower;
      upper_match_irq <= (mode == MODE_CASCADE16) ? both16
                       : (mode == MODE_PPG) ? (ppg_hi || match_upper) : match_upper;
    end
  end
endmodule : timer_pair_unit

`timescale 1ns/1ps
module timer_pair_block
  import timer_pair_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // external clock pin for pair b lower timer
  input  wire logic        ext_clk_pin,
  // timer outputs
  output logic             wave_out_a_pin,
  output logic             wave_out_b_pin,
  output logic [3:0]       match_irq
);
  logic [7:0] pair_a_mode_reg;
  logic [7:0] pair_b_mode_reg;
  logic [7:0] flop_control_reg;
  logic [7:0] run_control_reg;
  logic [7:0] dbuf_control_reg;
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic [PRESCALE_WIDTH-1:0] next_prescale;
  logic [2:0] taps;
  logic [1:0] ext_sync;
  logic       ext_last;
  logic       ext_tick;
  logic       wr;
  logic       wr_lane0;

  assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign wr_lane0 = wr && wb_sel_i[0];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pair_a_mode_reg  <= MODE_RESET;
      pair_b_mode_reg  <= MODE_RESET;
      flop_control_reg <= FLOP_RESET;
      run_control_reg  <= RUN_RESET;
      dbuf_control_reg <= DBUF_RESET;
    end
    else if (wr_lane0)
    begin
      if (wb_adr_i == ADDR_MODE_A)
        pair_a_mode_reg <= wb_dat_i[7:0];
      else if (wb_adr_i == ADDR_MODE_B)
        pair_b_mode_reg <= wb_dat_i[7:0];
      else if (wb_adr_i == ADDR_FLOP)
        flop_control_reg <= wb_dat_i[7:0];
      else if (wb_adr_i == ADDR_RUN)
        run_control_reg <= wb_dat_i[7:0];
      else if (wb_adr_i == ADDR_DBUF)
        dbuf_control_reg <= wb_dat_i[7:0];
    end
  end

  // flop, compare registers and unmapped addresses read as zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wb_dat_o <= 32'h00000000;
    else if (wb_adr_i == ADDR_MODE_A)
      wb_dat_o <= {24'h000000, pair_a_mode_reg};
    else if (wb_adr_i == ADDR_MODE_B)
      wb_dat_o <= {24'h000000, pair_b_mode_reg};
    else if (wb_adr_i == ADDR_RUN)
      wb_dat_o <= {24'h000000, run_control_reg};
    else if (wb_adr_i == ADDR_DBUF)
      wb_dat_o <= {24'h000000, dbuf_control_reg};
    else
      wb_dat_o <= 32'h00000000;
  end

  // prescaler; taps are one-cycle ticks at the carry out of each tap bit
  always_comb
  begin
    next_prescale = prescale + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prescale <= '0;
    else if (!run_control_reg[RUN_PRESCALE_BIT])
      prescale <= '0;
    else
      prescale <= next_prescale;
  end

  assign taps[0] = run_control_reg[RUN_PRESCALE_BIT] && (&prescale[TAP_FINE_BIT:0]);
  assign taps[1] = run_control_reg[RUN_PRESCALE_BIT] && (&prescale[TAP_MID_BIT:0]);
  assign taps[2] = run_control_reg[RUN_PRESCALE_BIT] && (&prescale[TAP_COARSE_BIT:0]);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_sync <= 2'h0;
      ext_last <= 1'b0;
    end
    else
    begin
      ext_sync <= {ext_sync[0], ext_clk_pin};
      ext_last <= ext_sync[1];
    end
  end
  assign ext_tick = ext_sync[1] && !ext_last;

  timer_pair_unit pair_a (
    .clk                  (clk),
    .nrst                 (nrst),
    .mode_reg             (pair_a_mode_reg),
    .flop_control_field   (wb_dat_i[FLOP_A_CTL_LSB +: 2]),
    .flop_ctl_write       (wr_lane0 && wb_adr_i == ADDR_FLOP),
    .toggle_enable        (flop_control_reg[FLOP_A_INV_BIT]),
    .toggle_source_select (flop_control_reg[FLOP_A_SRC_BIT]),
    .run_lower            (run_control_reg[RUN_LOWER_A_BIT]),
    .run_upper            (run_control_reg[RUN_UPPER_A_BIT]),
    .dbuf_enable          (dbuf_control_reg[DBUF_A_BIT]),
    .cmp_lower_write      (wr_lane0 && wb_adr_i == ADDR_CMP0),
    .cmp_upper_write      (wr_lane0 && wb_adr_i == ADDR_CMP1),
    .cmp_wdata            (wb_dat_i[7:0]),
    .taps                 (taps),
    .ext_tick             (1'b0),
    .has_ext              (1'b0),
    .lower_match_irq      (match_irq[0]),
    .upper_match_irq      (match_irq[1]),
    .toggle_out           (wave_out_a_pin)
  );

  // pair b upper compare sits one word above the lower
  timer_pair_unit pair_b (
    .clk                  (clk),
    .nrst                 (nrst),
    .mode_reg             (pair_b_mode_reg),
    .flop_control_field   (wb_dat_i[FLOP_B_CTL_LSB +: 2]),
    .flop_ctl_write       (wr_lane0 && wb_adr_i == ADDR_FLOP),
    .toggle_enable        (flop_control_reg[FLOP_B_INV_BIT]),
    .toggle_source_select (flop_control_reg[FLOP_B_SRC_BIT]),
    .run_lower            (run_control_reg[RUN_LOWER_B_BIT]),
    .run_upper            (run_control_reg[RUN_UPPER_B_BIT]),
    .dbuf_enable          (dbuf_control_reg[DBUF_B_BIT]),
    .cmp_lower_write      (wr_lane0 && wb_adr_i == ADDR_CMP2),
    .cmp_upper_write      (wr_lane0 && wb_adr_i == ADDR_CMP3),
    .cmp_wdata            (wb_dat_i[7:0]),
    .taps                 (taps),
    .ext_tick             (ext_tick),
    .has_ext              (1'b1),
    .lower_match_irq      (match_irq[2]),
    .upper_match_irq      (match_irq[3]),
    .toggle_out           (wave_out_b_pin)
  );
endmodule : timer_pair_block

// ---- test/timer_pair_block_monitor.sv ----
`timescale 1ns/1ps
module timer_pair_block_monitor
  import timer_pair_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins
  input wire logic        ext_clk_pin,
  input wire logic        wave_out_a_pin,
  input wire logic        wave_out_b_pin,
  input wire logic [3:0]  match_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic       req;
  logic [1:0] pair_a_mode;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // shadow of the pair a mode field, updated on taken writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pair_a_mode <= 2'h0;
    else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_MODE_A)
      pair_a_mode <= wb_dat_i[7:6];
  end

  sequence flop_write(logic [1:0] code);
    req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_FLOP && wb_dat_i[1:0] == code;
  endsequence

  sequence read_of(logic [5:0] a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence

  a_ack_follows_req: assert property (req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("ack without request");
  a_rdata_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_flop_reads_zero: assert property (read_of(ADDR_FLOP) |-> wb_dat_o == 32'h00000000)
    else $error("flop control readable");
  a_cmp_reads_zero: assert property ((read_of(ADDR_CMP0) or read_of(ADDR_CMP1) or read_of(ADDR_CMP2)
    or read_of(ADDR_CMP3)) |-> wb_dat_o == 32'h00000000) else $error("compare value readable");
  a_flop_clear_a: assert property (flop_write(FLOP_CLEAR) |=> !wave_out_a_pin)
    else $error("flop a not cleared");
  a_flop_set_a: assert property (flop_write(FLOP_SET) |=> wave_out_a_pin)
    else $error("flop a not set");
  a_flop_invert_a: assert property (flop_write(FLOP_INVERT) |=> wave_out_a_pin != $past(wave_out_a_pin))
    else $error("flop a not inverted");
  a_irq_one_pulse: assert property (match_irq[0] |=> !match_irq[0]) else $error("lower irq held");
  a_cascade_quiet: assert property (pair_a_mode == 2'h1 && $past(pair_a_mode) == 2'h1 |-> !match_irq[0])
    else $error("lower irq in cascade mode");
endmodule : timer_pair_block_monitor

// ---- test/pin_load_model.sv ----
`timescale 1ns/1ps
module pin_load_model
(
  // clock
  input  wire logic clk,
  // timer output pin
  input  wire logic pin_a,
  // external count clock
  output logic      ext_clk_pin,
  // last high and low widths in ns
  output int        high_ns,
  output int        low_ns
);
  realtime last_edge;
  int      div;

  initial
  begin
    ext_clk_pin = 1'b0;
    div = 0;
    high_ns = 0;
    low_ns = 0;
    last_edge = 0;
  end

  // free running count source, ten system clocks a period
  always @(posedge clk)
  begin
    div = (div == 4) ? 0 : div + 1;
    if (div == 0)
      ext_clk_pin <= ~ext_clk_pin;
  end

  always @(pin_a)
  begin
    if (pin_a === 1'b0)
      high_ns = int'($realtime - last_edge);
    else
      low_ns = int'($realtime - last_edge);
    last_edge = $realtime;
  end
endmodule : pin_load_model

// ---- test/test_timer_pair_block.sv ----
`timescale 1ns/1ps
`define CHECK_EQ(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module test_timer_pair_block
  import timer_pair_pkg::*;
;
  logic        clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_ack_o, ext_clk_pin, wave_out_a_pin, wave_out_b_pin, pin_before;
  logic [3:0]  match_irq;
  int          high_ns, low_ns, num_errors, n_compared;
  logic [1:0]  codes [5] = '{FLOP_CLEAR, FLOP_SET, FLOP_INVERT, FLOP_INVERT, FLOP_HOLD};
  logic        flop_exp [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  timer_pair_block uut (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_clk_pin(ext_clk_pin), .wave_out_a_pin(wave_out_a_pin), .wave_out_b_pin(wave_out_b_pin),
    .match_irq(match_irq));
  pin_load_model load (.clk(clk), .pin_a(wave_out_a_pin), .ext_clk_pin(ext_clk_pin), .high_ns(high_ns),
    .low_ns(low_ns));

  always #50 clk = ~clk;

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic wb_access(input logic we, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    int k;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      num_errors++;
      $display("Error wishbone ack expected 1 seen 0");
      print_verdict();
    end
  endtask : wb_access

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb_access(1'b1, a, d, q);
  endtask : wr

  task automatic rd_check(input logic [5:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    wb_access(1'b0, a, 8'h00, q);
    `CHECK_EQ(what, exp, q)
  endtask : rd_check

  // cycles between two pulses of one match line
  task automatic irq_gap(input int b, input int exp, input string what);
    int k;
    int g;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (match_irq[b] !== 1'b1 && k < 2000);
    // a first wait that runs out counts as a miss too
    g = (k < 2000) ? 0 : 2000;
    do
    begin
      @(posedge clk);
      g++;
    end
    while (match_irq[b] !== 1'b1 && g < 2000);
    `CHECK_EQ(what, exp, g)
    if (g >= 2000)
      print_verdict();
  endtask : irq_gap

  task automatic width_check(input int cycles, input int exp_min, input int exp_max, input string what);
    repeat (cycles) @(posedge clk);
    `CHECK_EQ({what, " short"}, exp_min, (high_ns < low_ns) ? high_ns : low_ns)
    `CHECK_EQ({what, " long"}, exp_max, (high_ns < low_ns) ? low_ns : high_ns)
  endtask : width_check

  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("Error run length expected end seen timeout");
    print_verdict();
  end

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    `CHECK_EQ("pin a reset", 1'b0, wave_out_a_pin)
    rd_check(ADDR_MODE_A, MODE_RESET, "mode a");
    rd_check(ADDR_RUN, RUN_RESET, "run");
    rd_check(ADDR_DBUF, DBUF_RESET, "dbuf");
    rd_check(ADDR_FLOP, 8'h00, "flop read");
    wr(ADDR_CMP0, 8'hA5);
    rd_check(ADDR_CMP0, 8'h00, "cmp0 read");
    wr(ADDR_MODE_B, 8'h5A);
    rd_check(ADDR_MODE_B, 8'h5A, "mode b");
    $display("test registers done");
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 5; i++)
      begin
        wr(ADDR_FLOP, j ? {2'b00, codes[i], 4'h3} : {4'h3, 2'b00, codes[i]});
        `CHECK_EQ("flop pin", flop_exp[i], j ? wave_out_b_pin : wave_out_a_pin)
      end
    $display("test software flop done");
    wr(ADDR_MODE_A, 8'h05);
    wr(ADDR_CMP1, 8'h03);
    wr(ADDR_FLOP, 8'h3E);
    wr(ADDR_RUN, 8'h82);
    irq_gap(1, 6, "upper gap");
    width_check(40, 600, 600, "square");
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_MODE_A, 8'h01);
    wr(ADDR_CMP0, 8'h02);
    wr(ADDR_RUN, 8'h83);
    irq_gap(0, 4, "lower gap");
    irq_gap(1, 12, "upper on lower match");
    width_check(60, 1200, 1200, "upper source");
    wr(ADDR_FLOP, 8'h36);
    width_check(40, 400, 400, "lower source");
    $display("test dual 8-bit done");
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_FLOP, 8'h3F);
    // upper clock select coarse, must be ignored
    wr(ADDR_MODE_A, 8'h4D);
    wr(ADDR_CMP0, 8'h04);
    wr(ADDR_CMP1, 8'h01);
    wr(ADDR_RUN, 8'h83);
    irq_gap(1, 520, "cascade gap");
    width_check(600, 52000, 52000, "cascade");
    // low byte alone must hold off the next full match
    wr(ADDR_CMP0, 8'h04);
    pin_before = wave_out_a_pin;
    repeat (600) @(posedge clk);
    `CHECK_EQ("cascade suspended", pin_before, wave_out_a_pin)
    $display("test 16-bit done");
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_MODE_A, 8'h81);
    wr(ADDR_CMP0, 8'h02);
    wr(ADDR_CMP1, 8'h05);
    wr(ADDR_FLOP, 8'h37);
    wr(ADDR_RUN, 8'h81);
    irq_gap(1, 10, "ppg period");
    width_check(40, 400, 600, "ppg");
    wr(ADDR_DBUF, 8'h01);
    wr(ADDR_CMP0, 8'h01);
    width_check(40, 200, 800, "ppg reload");
    $display("test ppg done");
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_DBUF, 8'h00);
    wr(ADDR_CMP0, 8'h0A);
    wr(ADDR_CMP1, 8'h03);
    for (int k = 1; k < 4; k++)
    begin
      wr(ADDR_RUN, 8'h00);
      wr(ADDR_MODE_A, 8'hC5 | 8'(k << 4));
      wr(ADDR_RUN, 8'h83);
      irq_gap(1, 6, "pwm upper timer");
      width_check(3 * (1 << (k + 6)), 2000, ((1 << (k + 5)) - 11) * 200, "pwm");
    end
    wr(ADDR_DBUF, 8'h01);
    wr(ADDR_CMP0, 8'h14);
    width_check(1600, 4000, 47000, "pwm reload");
    $display("test pwm done");
    wr(ADDR_RUN, 8'h00);
    wr(ADDR_DBUF, 8'h00);
    wr(ADDR_MODE_A, 8'h01);
    wr(ADDR_MODE_B, 8'h08);
    wr(ADDR_CMP0, 8'h00);
    wr(ADDR_CMP2, 8'h03);
    wr(ADDR_CMP3, 8'h02);
    rd_check(ADDR_CMP3, 8'h00, "cmp3 read");
    wr(ADDR_RUN, 8'h8D);
    irq_gap(2, 30, "external count");
    irq_gap(0, 512, "compare zero");
    irq_gap(3, 32, "upper mid tap");
    $display("test clock sources done");
    print_verdict();
  end
endmodule : test_timer_pair_block

bind timer_pair_block timer_pair_block_monitor mon (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_pin(ext_clk_pin), .wave_out_a_pin(wave_out_a_pin),
  .wave_out_b_pin(wave_out_b_pin), .match_irq(match_irq));
